/* File: shared/branch_consts.svh */
// Constants for the branch and addressing sequencer: opcodes, lengths, cycles, register offsets.
`ifndef BRANCH_CONSTS_SVH
`define BRANCH_CONSTS_SVH

// ****************************************************************
// Opcodes
// ****************************************************************
`define OP_NO_OPERATION 8'h00
`define OP_SPARE_NOP 8'ha5
`define OP_BIT_CLEAR 8'h30
`define OP_BIT_SET_CLEAR 8'h10
`define OP_LONG_CALL 8'h12
`define OP_LONG_JUMP 8'h02
`define OP_SUB_EXIT 8'h22
`define OP_INT_EXIT 8'h32
`define OP_SHORT_JUMP 8'h80
`define OP_INDIRECT 8'h73
`define OP_ACC_ZERO 8'h60
`define OP_ACC_NONZERO 8'h70
`define OP_CMP_DIR 8'hb5
`define OP_CMP_IMM_ACC 8'hb4
`define OP_DEC_DIR 8'hd5
`define OP_PAGE_LOW 4'h1
`define OP_PAGE_CALL_BIT 1'h1
`define OP_CMP_IND_HI 7'h5b
`define OP_CMP_REG_HI 5'h17
`define OP_DEC_REG_HI 5'h1b

// ****************************************************************
// Lengths in bytes and cycle counts
// ****************************************************************
`define LEN_1 2'h1
`define LEN_2 2'h2
`define LEN_3 2'h3
`define CYC_1 3'h1
`define CYC_2 3'h2
`define CYC_3 3'h3
`define CYC_4 3'h4
`define CYC_5 3'h5

// ****************************************************************
// Address map
// ****************************************************************
`define SFR_BASE 8'h80
`define DATA_POINTER_LOW_ADDR 8'h82
`define DATA_POINTER_HIGH_ADDR 8'h83
`define DATA_POINTER_RESET 8'h00
`define PAGE_BITS 11

`endif

/* File: shared/branch_pkg.sv */
// Types shared by the branch and addressing sequencer.
package branch_pkg;

  typedef enum {
    k_nop, k_bit_clear, k_bit_set_clear, k_page_call, k_long_call, k_sub_exit,
    k_int_exit, k_page_jump, k_long_jump, k_short_jump, k_indirect, k_acc_zero,
    k_acc_nonzero, k_cmp_dir, k_cmp_imm_acc, k_cmp_imm_ind, k_cmp_imm_reg,
    k_dec_reg, k_dec_dir, k_unknown
  } kind_t;

  typedef struct packed {
    logic [1:0] len;
    logic [2:0] cyc_not_taken;
    logic [2:0] cyc_taken;
  } timing_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] opcode;
    logic [7:0] op1;
    logic [7:0] op2;
  } instr_t;

  typedef struct packed {
    logic [7:0] acc;
    logic bit_value;
    logic [7:0] direct_value;
    logic [7:0] reg_value;
    logic [7:0] indirect_value;
    logic [15:0] return_pc;
  } ctx_t;

  typedef struct packed {
    logic [4:0] bank_reg_addr;
    logic [4:0] pointer_reg_addr;
    logic [7:0] direct_addr;
    logic direct_is_sfr;
    logic [7:0] bit_addr;
  } operand_addr_t;

  typedef struct packed {
    logic [15:0] next_pc;
    logic taken;
    logic illegal;
    logic push_return;
    logic [15:0] return_addr;
    logic pop_return;
    logic int_exit;
    logic bit_clear;
    logic write_reg;
    logic write_direct;
    logic [7:0] write_value;
    logic compare_less;
  } result_t;

endpackage

/* File: verilog/branch_sequencer.sv */
// Branch and addressing sequencer with the data pointer registers.
`timescale 1ns/1ps
`include "branch_consts.svh"

module branch_sequencer
(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_issue,
  input wire branch_pkg::instr_t i_instr,
  input wire logic [1:0] i_bank_select,
  input wire branch_pkg::ctx_t i_ctx,
  input wire logic i_sfr_rd,
  input wire logic i_sfr_wr,
  input wire logic [7:0] i_sfr_addr,
  input wire logic [7:0] i_sfr_wdata,
  output logic o_ready,
  output branch_pkg::operand_addr_t o_operand,
  output logic o_retire,
  output branch_pkg::result_t o_result,
  output logic [7:0] o_sfr_rdata,
  output logic o_sfr_hit
);

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic branch_pkg::kind_t decode_kind(input logic [7:0] op);
    branch_pkg::kind_t k;
    k = branch_pkg::k_unknown;
    if (op == `OP_NO_OPERATION || op == `OP_SPARE_NOP)
      k = branch_pkg::k_nop;
    else if (op == `OP_BIT_CLEAR)
      k = branch_pkg::k_bit_clear;
    else if (op == `OP_BIT_SET_CLEAR)
      k = branch_pkg::k_bit_set_clear;
    else if (op[3:0] == `OP_PAGE_LOW)
      k = (op[4] == `OP_PAGE_CALL_BIT) ? branch_pkg::k_page_call : branch_pkg::k_page_jump;
    else if (op == `OP_LONG_CALL)
      k = branch_pkg::k_long_call;
    else if (op == `OP_LONG_JUMP)
      k = branch_pkg::k_long_jump;
    else if (op == `OP_SUB_EXIT)
      k = branch_pkg::k_sub_exit;
    else if (op == `OP_INT_EXIT)
      k = branch_pkg::k_int_exit;
    else if (op == `OP_SHORT_JUMP)
      k = branch_pkg::k_short_jump;
    else if (op == `OP_INDIRECT)
      k = branch_pkg::k_indirect;
    else if (op == `OP_ACC_ZERO)
      k = branch_pkg::k_acc_zero;
    else if (op == `OP_ACC_NONZERO)
      k = branch_pkg::k_acc_nonzero;
    else if (op == `OP_CMP_DIR)
      k = branch_pkg::k_cmp_dir;
    else if (op == `OP_CMP_IMM_ACC)
      k = branch_pkg::k_cmp_imm_acc;
    else if (op[7:1] == `OP_CMP_IND_HI)
      k = branch_pkg::k_cmp_imm_ind;
    else if (op[7:3] == `OP_CMP_REG_HI)
      k = branch_pkg::k_cmp_imm_reg;
    else if (op[7:3] == `OP_DEC_REG_HI)
      k = branch_pkg::k_dec_reg;
    else if (op == `OP_DEC_DIR)
      k = branch_pkg::k_dec_dir;
    return k;
  endfunction

  function automatic branch_pkg::timing_t timing_of(input branch_pkg::kind_t k);
    branch_pkg::timing_t t;
    t = '{len: `LEN_1, cyc_not_taken: `CYC_1, cyc_taken: `CYC_1};
    case (k)
      branch_pkg::k_nop:
        t = '{len: `LEN_1, cyc_not_taken: `CYC_1, cyc_taken: `CYC_1};
      branch_pkg::k_bit_clear:
        t = '{len: `LEN_2, cyc_not_taken: `CYC_3, cyc_taken: `CYC_4};
      branch_pkg::k_bit_set_clear:
        t = '{len: `LEN_3, cyc_not_taken: `CYC_3, cyc_taken: `CYC_4};
      branch_pkg::k_page_call:
        t = '{len: `LEN_2, cyc_not_taken: `CYC_3, cyc_taken: `CYC_3};
      branch_pkg::k_long_call:
        t = '{len: `LEN_3, cyc_not_taken: `CYC_4, cyc_taken: `CYC_4};
      branch_pkg::k_sub_exit, branch_pkg::k_int_exit:
        t = '{len: `LEN_1, cyc_not_taken: `CYC_5, cyc_taken: `CYC_5};
      branch_pkg::k_page_jump, branch_pkg::k_short_jump:
        t = '{len: `LEN_2, cyc_not_taken: `CYC_3, cyc_taken: `CYC_3};
      branch_pkg::k_long_jump:
        t = '{len: `LEN_3, cyc_not_taken: `CYC_4, cyc_taken: `CYC_4};
      branch_pkg::k_indirect:
        t = '{len: `LEN_1, cyc_not_taken: `CYC_3, cyc_taken: `CYC_3};
      branch_pkg::k_acc_zero, branch_pkg::k_acc_nonzero:
        t = '{len: `LEN_2, cyc_not_taken: `CYC_2, cyc_taken: `CYC_3};
      branch_pkg::k_cmp_dir, branch_pkg::k_cmp_imm_ind:
        t = '{len: `LEN_3, cyc_not_taken: `CYC_4, cyc_taken: `CYC_5};
      branch_pkg::k_cmp_imm_acc, branch_pkg::k_cmp_imm_reg:
        t = '{len: `LEN_3, cyc_not_taken: `CYC_3, cyc_taken: `CYC_4};
      branch_pkg::k_dec_reg:
        t = '{len: `LEN_2, cyc_not_taken: `CYC_2, cyc_taken: `CYC_3};
      branch_pkg::k_dec_dir:
        t = '{len: `LEN_3, cyc_not_taken: `CYC_3, cyc_taken: `CYC_4};
      default:
        t = '{len: `LEN_1, cyc_not_taken: `CYC_1, cyc_taken: `CYC_1};
    endcase
    return t;
  endfunction

  // A bank register address is the bank base plus the register number.
  function automatic logic [4:0] bank_reg(input logic [1:0] bank, input logic [2:0] n);
    return {bank, n};
  endfunction

  function automatic logic is_sfr(input logic [7:0] addr);
    return addr >= `SFR_BASE;
  endfunction

  // ****************************************************************
  // Sequencer state
  // ****************************************************************
  typedef enum {st_idle, st_run} state_t;

  state_t state;
  branch_pkg::instr_t instr;
  branch_pkg::kind_t kind;
  branch_pkg::timing_t timing;
  logic [2:0] cnt;
  logic taken_q;
  logic cond;
  logic eff_taken;
  logic [2:0] total;
  logic [15:0] next_pc;
  logic [15:0] rel_target;
  logic [7:0] rel;
  logic [7:0] cmp_left;
  logic [7:0] cmp_right;
  logic [7:0] dec_value;
  logic [7:0] data_pointer_low;
  logic [7:0] data_pointer_high;
  branch_pkg::result_t next_result;

  assign kind = decode_kind(instr.opcode);
  assign timing = timing_of(kind);
  assign o_ready = (state == st_idle);

  // The offset is the final byte, except that the two-byte bit jump takes it from op2, the third byte.
  assign rel = (timing.len == `LEN_2 && kind != branch_pkg::k_bit_clear) ? instr.op1 : instr.op2;
  assign next_pc = instr.pc + 16'(timing.len);
  assign rel_target = next_pc + {{8{rel[7]}}, rel};

  always_comb
  begin
    cmp_left = i_ctx.acc;
    cmp_right = instr.op1;
    case (kind)
      branch_pkg::k_cmp_dir:
        cmp_right = i_ctx.direct_value;
      branch_pkg::k_cmp_imm_ind:
        cmp_left = i_ctx.indirect_value;
      branch_pkg::k_cmp_imm_reg:
        cmp_left = i_ctx.reg_value;
      default:
        cmp_left = i_ctx.acc;
    endcase
  end

  assign dec_value = ((kind == branch_pkg::k_dec_reg) ? i_ctx.reg_value
                                                       : i_ctx.direct_value) - 8'h01;

  always_comb
  begin
    case (kind)
      branch_pkg::k_bit_clear:
        cond = !i_ctx.bit_value;
      branch_pkg::k_bit_set_clear:
        cond = i_ctx.bit_value;
      branch_pkg::k_acc_zero:
        cond = (i_ctx.acc == 8'h00);
      branch_pkg::k_acc_nonzero:
        cond = (i_ctx.acc != 8'h00);
      branch_pkg::k_cmp_dir, branch_pkg::k_cmp_imm_acc,
      branch_pkg::k_cmp_imm_ind, branch_pkg::k_cmp_imm_reg:
        cond = (cmp_left != cmp_right);
      branch_pkg::k_dec_reg, branch_pkg::k_dec_dir:
        cond = (dec_value != 8'h00);
      branch_pkg::k_nop, branch_pkg::k_unknown:
        cond = 1'b0;
      default:
        cond = 1'b1;
    endcase
  end

  // The condition is judged in the first cycle after issue and held afterwards,
  // so operand values may change once that cycle is over.
  assign eff_taken = (cnt == 3'h1) ? cond : taken_q;
  assign total = eff_taken ? timing.cyc_taken : timing.cyc_not_taken;

  always_comb
  begin
    next_result = '0;
    next_result.next_pc = next_pc;
    next_result.taken = cond;
    next_result.illegal = (kind == branch_pkg::k_unknown);
    next_result.compare_less = (cmp_left < cmp_right);
    next_result.write_value = dec_value;
    case (kind)
      branch_pkg::k_page_call, branch_pkg::k_page_jump:
      begin
        next_result.next_pc = {next_pc[15:`PAGE_BITS], instr.opcode[7:5], instr.op1};
        next_result.push_return = (kind == branch_pkg::k_page_call);
      end
      branch_pkg::k_long_call, branch_pkg::k_long_jump:
      begin
        next_result.next_pc = {instr.op1, instr.op2};
        next_result.push_return = (kind == branch_pkg::k_long_call);
      end
      branch_pkg::k_sub_exit, branch_pkg::k_int_exit:
      begin
        next_result.next_pc = i_ctx.return_pc;
        next_result.pop_return = 1'b1;
        next_result.int_exit = (kind == branch_pkg::k_int_exit);
      end
      branch_pkg::k_indirect:
        next_result.next_pc = {data_pointer_high, data_pointer_low} + 16'(i_ctx.acc);
      branch_pkg::k_dec_reg, branch_pkg::k_dec_dir:
      begin
        next_result.write_reg = (kind == branch_pkg::k_dec_reg);
        next_result.write_direct = (kind == branch_pkg::k_dec_dir);
        if (cond)
          next_result.next_pc = rel_target;
      end
      branch_pkg::k_bit_set_clear:
      begin
        next_result.bit_clear = cond;
        if (cond)
          next_result.next_pc = rel_target;
      end
      branch_pkg::k_nop, branch_pkg::k_unknown:
        next_result.next_pc = next_pc;
      default:
        if (cond)
          next_result.next_pc = rel_target;
    endcase
    next_result.return_addr = next_pc;
  end

  // ****************************************************************
  // Issue, count and retire
  // ****************************************************************
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      state <= st_idle;
      cnt <= 3'h0;
      o_retire <= 1'b0;
    end
    else
    begin
      o_retire <= 1'b0;
      case (state)
        st_idle:
          if (i_issue)
          begin
            state <= st_run;
            cnt <= 3'h1;
          end
        st_run:
          if (cnt == total)
          begin
            state <= st_idle;
            o_retire <= 1'b1;
          end
          else
            cnt <= cnt + 3'h1;
        default:
          state <= st_idle;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      instr <= '0;
      o_operand <= '0;
    end
    else if (state == st_idle && i_issue)
    begin
      instr <= i_instr;
      o_operand.bank_reg_addr <= bank_reg(i_bank_select, i_instr.opcode[2:0]);
      o_operand.pointer_reg_addr <= bank_reg(i_bank_select, {2'h0, i_instr.opcode[0]});
      o_operand.direct_addr <= i_instr.op1;
      o_operand.direct_is_sfr <= is_sfr(i_instr.op1);
      o_operand.bit_addr <= i_instr.op1;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      taken_q <= 1'b0;
      o_result <= '0;
    end
    else if (state == st_run && cnt == 3'h1)
    begin
      taken_q <= cond;
      o_result <= next_result;
    end
  end

  // ****************************************************************
  // Data pointer registers
  // ****************************************************************
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      data_pointer_low <= `DATA_POINTER_RESET;
      data_pointer_high <= `DATA_POINTER_RESET;
    end
    else if (i_sfr_wr)
    begin
      if (i_sfr_addr == `DATA_POINTER_LOW_ADDR)
        data_pointer_low <= i_sfr_wdata;
      if (i_sfr_addr == `DATA_POINTER_HIGH_ADDR)
        data_pointer_high <= i_sfr_wdata;
    end
  end

  // Reads answer one cycle later; an address outside this pair reads zero without a hit.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      o_sfr_rdata <= 8'h00;
      o_sfr_hit <= 1'b0;
    end
    else
    begin
      o_sfr_hit <= i_sfr_rd && (i_sfr_addr == `DATA_POINTER_LOW_ADDR ||
                                i_sfr_addr == `DATA_POINTER_HIGH_ADDR);
      if (i_sfr_rd && i_sfr_addr == `DATA_POINTER_LOW_ADDR)
        o_sfr_rdata <= data_pointer_low;
      else if (i_sfr_rd && i_sfr_addr == `DATA_POINTER_HIGH_ADDR)
        o_sfr_rdata <= data_pointer_high;
      else
        o_sfr_rdata <= 8'h00;
    end
  end

endmodule

/* File: test/branch_sequencer_asserts.sv */
// Concurrent checks on the ports of the branch and addressing sequencer.
`timescale 1ns/1ps
`include "branch_consts.svh"
module branch_sequencer_asserts
(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic i_issue,
  input wire branch_pkg::instr_t i_instr,
  input wire logic [1:0] i_bank_select,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_addr,
  input wire logic o_ready,
  input wire branch_pkg::operand_addr_t o_operand,
  input wire logic o_retire,
  input wire branch_pkg::result_t o_result,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_sfr_hit
);
  // ****************************************************************
  // Helper state
  // ****************************************************************
  // The captured instruction stays put until the next accepted issue, so checks at retire see it.
  branch_pkg::instr_t cap;
  logic [3:0] cnt;
  logic [15:0] pc2;
  logic go;
  assign go = i_issue && o_ready;
  assign pc2 = cap.pc + 16'h0002;
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
      cap <= '0;
    else if (go)
      cap <= i_instr;
  end
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst || go)
      cnt <= 4'h0;
    else if (cnt != 4'hf)
      cnt <= cnt + 4'h1;
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_nop_one_cycle: assert property (
    go && (i_instr.opcode == `OP_NO_OPERATION || i_instr.opcode == `OP_SPARE_NOP)
    |=> !o_retire ##1 o_retire) else $error("no-operation did not retire after one cycle");
  a_long_four_cycles: assert property (
    go && (i_instr.opcode == `OP_LONG_CALL || i_instr.opcode == `OP_LONG_JUMP)
    |=> !o_retire [*4] ##1 o_retire) else $error("long branch did not take four cycles");
  a_exit_five_cycles: assert property (
    go && (i_instr.opcode == `OP_SUB_EXIT || i_instr.opcode == `OP_INT_EXIT)
    |=> !o_retire [*5] ##1 o_retire) else $error("exit did not take five cycles");
  a_short_target: assert property (
    o_retire && cap.opcode == `OP_SHORT_JUMP
    |-> o_result.next_pc == pc2 + {{8{cap.op1[7]}}, cap.op1}) else $error("short jump target");
  a_long_target: assert property (
    o_retire && cap.opcode == `OP_LONG_JUMP |-> o_result.next_pc == {cap.op1, cap.op2})
    else $error("long jump target");
  a_page_target: assert property (
    o_retire && cap.opcode[3:0] == 4'h1
    |-> o_result.next_pc == {pc2[15:11], cap.opcode[7:5], cap.op1}) else $error("page target");
  a_bank_operand: assert property (
    go |=> o_operand.bank_reg_addr == {$past(i_bank_select), cap.opcode[2:0]})
    else $error("bank register address");
  a_direct_space: assert property (
    o_operand.direct_is_sfr == o_operand.direct_addr[7]) else $error("direct space split");
  a_acc_cycles: assert property (
    o_retire && (cap.opcode == `OP_ACC_ZERO || cap.opcode == `OP_ACC_NONZERO)
    |-> cnt == (o_result.taken ? 4'h3 : 4'h2)) else $error("accumulator jump cycle count");
  a_sfr_unmapped: assert property (
    i_sfr_rd && i_sfr_addr != 8'h82 && i_sfr_addr != 8'h83 |=> !o_sfr_hit && o_sfr_rdata == 8'h00)
    else $error("unmapped special register answered");
  c_taken: cover property (o_retire && o_result.taken);
  c_sfr_hit: cover property (o_sfr_hit);
  c_indirect: cover property (go && i_instr.opcode == `OP_INDIRECT);
endmodule

/* File: test/data_memory_model.sv */
// Behavioural internal data memory answering the sequencer's operand addresses.
`timescale 1ns/1ps
module data_memory_model
(
  input wire branch_pkg::operand_addr_t i_operand,
  output logic [7:0] o_direct_value,
  output logic [7:0] o_reg_value,
  output logic [7:0] o_indirect_value
);
  // Unwritten cells read unknown on purpose, so a wrong address never reads a lucky value.
  logic [7:0] mem [256];
  assign o_direct_value = mem[i_operand.direct_addr];
  assign o_reg_value = mem[{3'h0, i_operand.bank_reg_addr}];
  assign o_indirect_value = mem[mem[{3'h0, i_operand.pointer_reg_addr}]];
endmodule

/* File: test/tb_top.sv */
// Self-checking bench for the branch and addressing sequencer.
`timescale 1ns/1ps
`include "branch_consts.svh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module tb_top;
  logic i_sys_clk = 1'b0;
  logic srst = 1'b1;
  logic issue = 1'b0;
  branch_pkg::instr_t instr = '0;
  logic [1:0] bank = 2'h0;
  branch_pkg::ctx_t ctx;
  logic sfr_rd = 1'b0;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] acc = 8'h00;
  logic bitv = 1'b0;
  logic [15:0] rpc = 16'h0000;
  logic ready, retire, hit, t;
  branch_pkg::operand_addr_t operand;
  branch_pkg::result_t result;
  logic [7:0] rdata, dval, rval, ival;
  logic [15:0] len;
  int miscompares = 0;
  int checks_done = 0;
  always #2 i_sys_clk = ~i_sys_clk;
  always_comb ctx = '{acc: acc, bit_value: bitv, direct_value: dval, reg_value: rval,
    indirect_value: ival, return_pc: rpc};
  branch_sequencer i_dut (.i_sys_clk(i_sys_clk), .i_srst(srst), .i_issue(issue),
    .i_instr(instr), .i_bank_select(bank), .i_ctx(ctx), .i_sfr_rd(sfr_rd), .i_sfr_wr(sfr_wr),
    .i_sfr_addr(sfr_addr), .i_sfr_wdata(sfr_wdata), .o_ready(ready), .o_operand(operand),
    .o_retire(retire), .o_result(result), .o_sfr_rdata(rdata), .o_sfr_hit(hit));
  data_memory_model i_mem (.i_operand(operand), .o_direct_value(dval), .o_reg_value(rval),
    .o_indirect_value(ival));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic wrap_up;
    if (miscompares == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Leaves the bench in the retire cycle, so the next call issues back to back.
  task automatic run(input logic [15:0] pc, input logic [7:0] op, a, b, input logic [1:0] bk,
    input int cyc, input logic [15:0] npc);
    int n;
    issue = 1'b1;
    instr = '{pc: pc, opcode: op, op1: a, op2: b};
    bank = bk;
    @(posedge i_sys_clk);
    #1;
    issue = 1'b0;
    n = 0;
    while (retire !== 1'b1)
    begin
      @(posedge i_sys_clk);
      #1;
      n++;
      if (n > 8)
      begin
        miscompares++;
        wrap_up;
      end
    end
    `CHK("cycles", cyc, n)
    `CHK("next_pc", npc, result.next_pc)
  endtask
  task automatic sfr_write(input logic [7:0] ad, d);
    sfr_wr = 1'b1;
    sfr_addr = ad;
    sfr_wdata = d;
    @(posedge i_sys_clk);
    #1;
    sfr_wr = 1'b0;
    @(posedge i_sys_clk);
    #1;
  endtask
  task automatic sfr_check(input logic [7:0] ad, d, input logic h);
    sfr_rd = 1'b1;
    sfr_addr = ad;
    @(posedge i_sys_clk);
    #1;
    sfr_rd = 1'b0;
    `CHK("sfr_rdata", d, rdata)
    `CHK("sfr_hit", h, hit)
    @(posedge i_sys_clk);
    #1;
  endtask
  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial
  begin
    repeat (20) @(posedge i_sys_clk);
    #1;
    srst = 1'b0;
    `CHK("ready", 1'b1, ready)
    sfr_check(8'h82, 8'h00, 1'b1);
    sfr_check(8'h83, 8'h00, 1'b1);
    sfr_write(8'h82, 8'h5a);
    sfr_write(8'h83, 8'h12);
    sfr_check(8'h82, 8'h5a, 1'b1);
    sfr_check(8'h83, 8'h12, 1'b1);
    sfr_check(8'h81, 8'h00, 1'b0);
    i_mem.mem[8'h30] = 8'h55;
    i_mem.mem[8'h11] = 8'h40;
    i_mem.mem[8'h40] = 8'h99;
    i_mem.mem[8'h1b] = 8'h22;
    i_mem.mem[8'h09] = 8'h01;
    i_mem.mem[8'h85] = 8'h02;
    run(16'h0050, `OP_NO_OPERATION, 8'h00, 8'h00, 2'h0, 1, 16'h0051);
    run(16'h0051, `OP_SPARE_NOP, 8'h00, 8'h00, 2'h0, 1, 16'h0052);
    `CHK("illegal", 1'b0, result.illegal)
    run(16'h0100, `OP_SHORT_JUMP, 8'h80, 8'h00, 2'h0, 3, 16'h0082);
    run(16'h07fe, 8'he1, 8'h34, 8'h00, 2'h0, 3, 16'h0f34);
    run(16'h07fe, 8'hf1, 8'h34, 8'h00, 2'h0, 3, 16'h0f34);
    `CHK("push_return", 1'b1, result.push_return)
    `CHK("return_addr", 16'h0800, result.return_addr)
    run(16'h0600, `OP_LONG_CALL, 8'h1f, 8'hff, 2'h0, 4, 16'h1fff);
    `CHK("return_addr", 16'h0603, result.return_addr)
    run(16'h0700, `OP_LONG_JUMP, 8'h00, 8'h02, 2'h0, 4, 16'h0002);
    rpc = 16'h1234;
    run(16'h0800, `OP_SUB_EXIT, 8'h00, 8'h00, 2'h0, 5, 16'h1234);
    `CHK("pop_return", 1'b1, result.pop_return)
    run(16'h0800, `OP_INT_EXIT, 8'h00, 8'h00, 2'h0, 5, 16'h1234);
    `CHK("int_exit", 1'b1, result.int_exit)
    acc = 8'hf0;
    run(16'h0900, `OP_INDIRECT, 8'h00, 8'h00, 2'h0, 3, 16'h134a);
    for (int k = 0; k < 4; k++)
    begin
      acc = k[0] ? 8'h01 : 8'h00;
      t = k[0] == k[1];
      run(16'h0200, k[1] ? `OP_ACC_NONZERO : `OP_ACC_ZERO, 8'h10, 8'h00, 2'h0, t ? 3 : 2,
        t ? 16'h0212 : 16'h0202);
      `CHK("taken", t, result.taken)
    end
    for (int k = 0; k < 4; k++)
    begin
      bitv = k[0];
      t = k[1] ? k[0] : !k[0];
      len = k[1] ? 16'h0003 : 16'h0002;
      run(16'h0300, k[1] ? `OP_BIT_SET_CLEAR : `OP_BIT_CLEAR, 8'h20, 8'h05, 2'h0, t ? 4 : 3,
        16'h0300 + len + (t ? 16'h0005 : 16'h0000));
      `CHK("bit_clear", k[1] && t, result.bit_clear)
    end
    acc = 8'h55;
    run(16'h0400, `OP_CMP_DIR, 8'h30, 8'hfc, 2'h0, 4, 16'h0403);
    acc = 8'h56;
    run(16'h0400, `OP_CMP_DIR, 8'h30, 8'hfc, 2'h0, 5, 16'h03ff);
    run(16'h0400, 8'hb7, 8'h99, 8'hfc, 2'h2, 4, 16'h0403);
    `CHK("pointer_reg_addr", 5'h11, operand.pointer_reg_addr)
    run(16'h0400, 8'hb7, 8'h98, 8'hfc, 2'h2, 5, 16'h03ff);
    acc = 8'h07;
    run(16'h0400, `OP_CMP_IMM_ACC, 8'h07, 8'hfc, 2'h0, 3, 16'h0403);
    run(16'h0400, `OP_CMP_IMM_ACC, 8'h08, 8'hfc, 2'h0, 4, 16'h03ff);
    run(16'h0400, 8'hbb, 8'h22, 8'hfc, 2'h3, 3, 16'h0403);
    `CHK("bank_reg_addr", 5'h1b, operand.bank_reg_addr)
    run(16'h0400, 8'hbb, 8'h23, 8'hfc, 2'h3, 4, 16'h03ff);
    run(16'h0500, 8'hd9, 8'hf0, 8'h00, 2'h1, 2, 16'h0502);
    `CHK("write_reg", 1'b1, result.write_reg)
    `CHK("write_value", 8'h00, result.write_value)
    i_mem.mem[8'h09] = 8'h05;
    run(16'h0500, 8'hd9, 8'hf0, 8'h00, 2'h1, 3, 16'h04f2);
    `CHK("write_value", 8'h04, result.write_value)
    run(16'h0500, `OP_DEC_DIR, 8'h85, 8'h10, 2'h0, 4, 16'h0513);
    `CHK("write_value", 8'h01, result.write_value)
    `CHK("direct_is_sfr", 1'b1, operand.direct_is_sfr)
    // A reset after the last instruction retires, with the sequencer idle, must bring both pointer bytes back to zero.
    srst = 1'b1;
    @(posedge i_sys_clk);
    #1;
    srst = 1'b0;
    `CHK("ready", 1'b1, ready)
    sfr_check(8'h82, 8'h00, 1'b1);
    sfr_check(8'h83, 8'h00, 1'b1);
    wrap_up;
  end
endmodule
bind branch_sequencer branch_sequencer_asserts i_chk (.i_sys_clk, .i_srst, .i_issue, .i_instr,
  .i_bank_select, .i_sfr_rd, .i_sfr_addr, .o_ready, .o_operand, .o_retire, .o_result,
  .o_sfr_rdata, .o_sfr_hit);
